/* File: bench/port_pin_function_mux_bench.sv */
// Purpose: self-checking bench for the port pin mux
// Assumes: internal reset stretch cut to 16 clocks
// Notes:   read data checked by a monitor from a queue
`timescale 1ns/10ps
`default_nettype none
`include "ppfm_regs.svh"
module port_pin_function_mux_bench;
  // Bus side
  logic        mclk = 0, resetn = 0, reset_pin_n = 0, hwrite = 0, hready, hresp, rd_ph = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, exp_q[$];
  // Pin and peripheral side
  logic        timer2_out = 0, timer3_out = 0, buzzer_out = 0, ac_zero_cross_in = 0;
  logic        interrupt_one, zero_cross_irq_src, int_rst_active;
  logic [2:0]  key_irq_req, port3_in, port3_out, port3_oe_n, port3_pullup_en, ext_v = 0, ext_e = 0;
  logic [3:0]  port1_in = 0, port2_in = 0, port1_out, port1_oe_n, port2_out, port2_oe_n;
  logic [3:0]  port2_pullup_en, analog_in_en;
  int          n_mismatch = 0, compares = 0;

  // Clock at 25 MHz
  always #20 mclk = ~mclk;

  ppfm_top #(.RST_STRETCH_CLKS(16)) dut_u (.hsel(1'b1), .hsize(3'b010), .hreadyout(hready), .*);
  ppfm_pin_model pins_u (.pin_out(port3_out), .pin_oe_n(port3_oe_n), .pull_en(port3_pullup_en),
    .ext_val(ext_v), .ext_en(ext_e), .level(port3_in));

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single transfer; waits on ready with no assumed latency
  task automatic bus(input logic w, input logic [11:0] i, input logic [31:0] d);
    haddr <= {18'h0, i, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    if (!w)
      exp_q.push_back(d);
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
  endtask

  task automatic end_of_test;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Pops the oldest note when a read data phase completes
  always @(posedge mclk)
  begin
    if (rd_ph && hready === 1'b1)
      cmp("hrdata", exp_q.pop_front(), hrdata);
    if (hready === 1'b1)
      rd_ph = htrans === 2'b10 && !hwrite;
  end

  initial
  begin
    logic [31:0] r;
    logic [6:0]  e;
    logic [2:0]  e3;
    int          n;
    void'($urandom(79014));
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    cmp("oe3", 3'b110, port3_oe_n);
    cmp("pu3", 0, port3_pullup_en);
    r[0] = port3_out[0];
    @(posedge mclk);
    reset_pin_n <= 1'b1;
    @(negedge mclk);
    cmp("sync", !r[0], port3_out[0]);
    n = 0;
    while (int_rst_active !== 1'b0)
    begin
      @(posedge mclk);
      n++;
    end
    cmp("stretch", 1, n inside {[18:22]});
    @(negedge mclk);
    cmp("oe3", 3'b111, port3_oe_n);
    @(posedge mclk);
    // Random direction, pull-up, drive and latch on ports 2 and 3
    repeat (4)
    begin
      r = $urandom;
      e = ~(r[6:0] & ~(r[20:14] & r[27:21]));
      bus(1, `PPFM_IDX_PORT23_DIR, r[6:0]);
      bus(1, `PPFM_IDX_PORT23_PULLUP, r[13:7]);
      bus(1, `PPFM_IDX_PORT23_DRIVE, r[20:14]);
      bus(1, `PPFM_IDX_PORT23_DATA, r[27:21]);
      bus(0, `PPFM_IDX_PORT23_DIR, r[6:0]);
      @(negedge mclk);
      cmp("oe23", e, {port3_oe_n, port2_oe_n});
      cmp("pu23", r[13:7], {port3_pullup_en, port2_pullup_en});
      cmp("out23", r[27:21] & ~e, {port3_out, port2_out} & ~e);
      @(posedge mclk);
    end
    bus(1, `PPFM_IDX_PORT23_DIR, 0);
    // Key enables, zero-cross source and analog select on input pins
    repeat (4)
    begin
      r = $urandom;
      e3 = {r[5], r[18] ? r[19] : r[4], r[3]};
      ext_e <= 3'b111;
      ext_v <= r[5:3];
      port1_in <= r[9:6];
      port2_in <= r[13:10];
      ac_zero_cross_in <= r[19];
      bus(1, `PPFM_IDX_KEY_IRQ, r[2:0]);
      bus(1, `PPFM_IDX_ANALOG_SEL, r[17:14]);
      bus(1, `PPFM_IDX_ZERO_CROSS, {r[18], 1'b0});
      repeat (6) @(posedge mclk);
      bus(0, `PPFM_IDX_PIN_STATUS, {e3, r[13:10] & ~r[17:14], r[9:6]});
      @(negedge mclk);
      cmp("key", r[2:0] & e3, key_irq_req);
      cmp("interrupt_one", e3[1], interrupt_one);
      cmp("zc", r[19], zero_cross_irq_src);
      cmp("an", r[17:14], analog_in_en);
      @(posedge mclk);
    end
    ext_e <= 3'b000;
    bus(1, `PPFM_IDX_PORT1_DIR, 4'hF);
    bus(1, `PPFM_IDX_PORT23_DIR, 7'h70);
    bus(1, `PPFM_IDX_ZERO_CROSS, 1);
    @(negedge mclk);
    r[0] = port3_out[0];
    @(negedge mclk);
    cmp("sync", !r[0], port3_out[0]);
    @(posedge mclk);
    bus(1, `PPFM_IDX_ZERO_CROSS, 0);
    // Every mix of timer select, timer pin and buzzer, with PWM enables
    for (int m = 0; m < 8; m++)
    begin
      r = $urandom;
      timer2_out <= r[0];
      timer3_out <= r[1];
      buzzer_out <= r[2];
      bus(1, `PPFM_IDX_PORT01_DATA, r[7:4]);
      bus(1, `PPFM_IDX_PORT23_DATA, {r[3], 6'h0});
      bus(1, `PPFM_IDX_TIMER_MODE, m[2]);
      bus(1, `PPFM_IDX_TIMER_OUT, m[1]);
      bus(1, `PPFM_IDX_BUZZER, {r[11:8], 3'b000, m[0]});
      @(negedge mclk);
      cmp("p32", m[1] ? r[m[2]] : m[0] ? r[2] : r[3], port3_out[2]);
      cmp("p1", r[7:4] & ~(r[11:8] & ~{4{r[m[2]]}}), port1_out);
      cmp("oe1", 0, port1_oe_n);
      @(posedge mclk);
    end
    bus(0, 12'h004, 0);
    @(posedge mclk);
    end_of_test();
  end

  // Cuts a hang short
  initial
  begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: bench/ppfm_pin_model.sv */
// Purpose: outside circuitry on the port 3 pins
// Assumes: a floating pin shows the inverse of the mux value
// Notes:   ext_en lets the bench drive a released pin
`timescale 1ns/10ps
`default_nettype none
module ppfm_pin_model (
  // From the mux
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe_n,
  input  wire logic [2:0] pull_en,
  // Outside driver
  input  wire logic [2:0] ext_val,
  input  wire logic [2:0] ext_en,
  // Level back into the mux
  output logic      [2:0] level
);
  // Mux drive first, then outside driver, then pull-up; floating reads the inverse of pin_out
  assign level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
               | (pin_oe_n & ~ext_en & (pull_en | ~pin_out));
endmodule
`default_nettype wire

/* File: logic/ppfm_pkg.sv */
// Purpose: types shared by the pin mux files
// Assumes: nothing
// Notes:   numeric constants live in ppfm_regs.svh
package ppfm_pkg;

  // Decoded register select
  typedef enum {
    PPFM_R_NONE, PPFM_R_PORT01_DATA, PPFM_R_PORT23_DATA, PPFM_R_PORT1_DIR,
    PPFM_R_PORT23_DIR, PPFM_R_PORT23_PULLUP, PPFM_R_PORT1_DRIVE, PPFM_R_PORT23_DRIVE,
    PPFM_R_KEY_IRQ, PPFM_R_ZERO_CROSS, PPFM_R_TIMER_MODE, PPFM_R_TIMER_OUT,
    PPFM_R_BUZZER, PPFM_R_ANALOG_SEL, PPFM_R_PIN_STATUS
  } ppfm_reg_t;

  // Bus slave data phase
  typedef enum {
    PPFM_ST_IDLE, PPFM_ST_WRITE, PPFM_ST_RDWAIT, PPFM_ST_RDOUT
  } ppfm_ahb_st_t;

endpackage

/* File: logic/ppfm_regs.svh */
// Purpose: register indices, field positions, reset values and counts of the pin mux
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef PPFM_REGS_SVH
`define PPFM_REGS_SVH

// Register indices
`define PPFM_IDX_PORT01_DATA   12'h000
`define PPFM_IDX_PORT23_DATA   12'h002
`define PPFM_IDX_PORT1_DIR     12'h010
`define PPFM_IDX_PORT23_DIR    12'h012
`define PPFM_IDX_PORT23_PULLUP 12'h022
`define PPFM_IDX_PORT1_DRIVE   12'h028
`define PPFM_IDX_PORT23_DRIVE  12'h02A
`define PPFM_IDX_KEY_IRQ       12'h038
`define PPFM_IDX_ZERO_CROSS    12'h03A
`define PPFM_IDX_TIMER_MODE    12'h05E
`define PPFM_IDX_TIMER_OUT     12'h06A
`define PPFM_IDX_BUZZER        12'h06C
`define PPFM_IDX_ANALOG_SEL    12'h080
`define PPFM_IDX_PIN_STATUS    12'h082

// Field positions
`define PPFM_P3_LSB            4
`define PPFM_ZC_SYNC_SEL_BIT   0
`define PPFM_ZC_INPUT_SEL_BIT  1
`define PPFM_TM_SEL_BIT        0
`define PPFM_TCO_EN_BIT        0
`define PPFM_BZ_EN_BIT         0
`define PPFM_PWM_EN_LSB        4

// Reset values
`define PPFM_RST4              4'h0
`define PPFM_RST7              7'h00
`define PPFM_RST8              8'h00

// Oscillator counts of internal reset after the reset pin rises
`define PPFM_RST_STRETCH_CLKS  16384

`endif

/* File: logic/ppfm_rst_stretch.sv */
// Purpose: holds internal reset for a fixed count after the reset pin releases
// Assumes: pin level already synchronised; mclk is the oscillator clock
// Notes:   count is a parameter so simulation can shorten it
`timescale 1ns/10ps
`default_nettype none
module ppfm_rst_stretch #(
  parameter int unsigned COUNT = 16384
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Reset pin level, high when released
  input  wire logic pin_ok,
  // Internal reset, high while asserted
  output logic      int_rst_q
);

  logic [14:0] cnt_q;
  logic [15:0] hcnt_q;

  // Count oscillator cycles while the pin stays released
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q     <= 15'h0000;
      int_rst_q <= 1'b1;
    end
    else if (!pin_ok)
    begin
      cnt_q     <= 15'h0000;
      int_rst_q <= 1'b1;
    end
    else if (int_rst_q)
    begin
      if (cnt_q == 15'(COUNT - 1))
        int_rst_q <= 1'b0;
      else
        cnt_q <= cnt_q + 15'h0001;
    end
  end

  // Helper: cycles since pin release, saturating
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      hcnt_q <= 16'h0000;
    else if (!pin_ok)
      hcnt_q <= 16'h0000;
    else if (hcnt_q != 16'hFFFF)
      hcnt_q <= hcnt_q + 16'h0001;
  end

  a_stretch_length: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(int_rst_q) |-> hcnt_q == 16'(COUNT))
    else $error("internal reset released at wrong count");

  a_stretch_hold: assert property (@(posedge mclk) disable iff (!resetn)
    !pin_ok |=> int_rst_q)
    else $error("internal reset not held while pin low");

endmodule
`default_nettype wire

/* File: logic/ppfm_sync3.sv */
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs are asynchronous to mclk
// Notes:   output moves only when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module ppfm_sync3 #(
  parameter int W = 13
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         resetn,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a change per bit once stages agree
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      sync_out <= '0;
    else
      sync_out <= (s2_q & s3_q) | (sync_out & (s2_q ^ s3_q));
  end

endmodule
`default_nettype wire

/* File: logic/ppfm_top.sv */
// Purpose: pin function mux for ports 1, 2 and 3 with AHB-Lite register slave
// Assumes: single word transfers; timers, buzzer and zero-cross detector outside
// Notes:   reads take one wait state, writes none; registers cleared in reset
//
// Overview of operation
// - Port 3 bits set input or output individually
// - Port 3 pull-ups enabled per bit
// - Port 3 push-pull or open-drain per bit
// - Reset leaves port 3 as input, no pull-up
// - Bit 0 drives clock sync during internal reset
// - After reset bit 0 selects sync or latch
// - Zero-cross signal feeds interrupt and bit 1 input
// - Zero-cross register picks bit 1 input source
// - Bit 1 is interrupt one request input
// - Buzzer register picks bit 2 buzzer or latch
// - Timer output register picks bit 2 timer
// - Key interrupts on bits 0-2 enabled individually
// - Port 2 gives four analog inputs
// - Buzzer register enables PWM per port 1 bit
// - PWM pin is timer AND port latch
// - Internal reset lasts 2^14 clocks after release
`timescale 1ns/10ps
`default_nettype none
`include "ppfm_regs.svh"
module ppfm_top
  import ppfm_pkg::*;
#(
  parameter int unsigned RST_STRETCH_CLKS = `PPFM_RST_STRETCH_CLKS
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        reset_pin_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Peripheral signals
  input  wire logic        timer2_out,
  input  wire logic        timer3_out,
  input  wire logic        buzzer_out,
  input  wire logic        ac_zero_cross_in,
  output logic             interrupt_one,
  output logic             zero_cross_irq_src,
  output logic      [2:0]  key_irq_req,
  output logic             int_rst_active,
  // Port 1 pins
  input  wire logic [3:0]  port1_in,
  output logic      [3:0]  port1_out,
  output logic      [3:0]  port1_oe_n,
  // Port 2 pins
  input  wire logic [3:0]  port2_in,
  output logic      [3:0]  port2_out,
  output logic      [3:0]  port2_oe_n,
  output logic      [3:0]  port2_pullup_en,
  output logic      [3:0]  analog_in_en,
  // Port 3 pins
  input  wire logic [2:0]  port3_in,
  output logic      [2:0]  port3_out,
  output logic      [2:0]  port3_oe_n,
  output logic      [2:0]  port3_pullup_en
);

  // Software registers
  logic [3:0]   port1_latch_q;
  logic [6:0]   port23_latch_q;
  logic [3:0]   port1_direction_q;
  logic [6:0]   port23_direction_reg_q;
  logic [6:0]   port23_pullup_reg_q;
  logic [3:0]   port1_drive_q;
  logic [6:0]   port23_drive_structure_reg_q;
  logic [2:0]   key_irq_control_reg_q;
  logic [1:0]   zero_cross_control_reg_q;
  logic         timer_mode_control_reg_q;
  logic         timer_output_control_reg_q;
  logic [7:0]   buzzer_control_reg_q;
  logic [3:0]   analog_sel_q;
  // Bus state
  ppfm_ahb_st_t ahb_st_q;
  ppfm_reg_t    reg_q;
  logic         addr_ok;
  logic [11:0]  rd_mux;
  // Pin side
  logic [12:0]  pin_sync;
  logic [3:0]   p1_s;
  logic [3:0]   p2_s;
  logic [2:0]   p3_s;
  logic         ac_s;
  logic         rst_pin_s;
  logic         int_rst;
  logic         sysclk_sync_out_q;
  logic         timer_sel;
  logic         timer_out_pin;
  logic [2:0]   p3_eff;
  logic [10:0]  val_all;
  logic [10:0]  drv_all;
  logic [10:0]  od_all;
  logic [10:0]  oe_n_all;

  // Register index to select; haddr above bit 13 is not decoded
  function automatic ppfm_reg_t reg_decode(input logic [11:0] idx);
    case (idx)
      `PPFM_IDX_PORT01_DATA:   return PPFM_R_PORT01_DATA;
      `PPFM_IDX_PORT23_DATA:   return PPFM_R_PORT23_DATA;
      `PPFM_IDX_PORT1_DIR:     return PPFM_R_PORT1_DIR;
      `PPFM_IDX_PORT23_DIR:    return PPFM_R_PORT23_DIR;
      `PPFM_IDX_PORT23_PULLUP: return PPFM_R_PORT23_PULLUP;
      `PPFM_IDX_PORT1_DRIVE:   return PPFM_R_PORT1_DRIVE;
      `PPFM_IDX_PORT23_DRIVE:  return PPFM_R_PORT23_DRIVE;
      `PPFM_IDX_KEY_IRQ:       return PPFM_R_KEY_IRQ;
      `PPFM_IDX_ZERO_CROSS:    return PPFM_R_ZERO_CROSS;
      `PPFM_IDX_TIMER_MODE:    return PPFM_R_TIMER_MODE;
      `PPFM_IDX_TIMER_OUT:     return PPFM_R_TIMER_OUT;
      `PPFM_IDX_BUZZER:        return PPFM_R_BUZZER;
      `PPFM_IDX_ANALOG_SEL:    return PPFM_R_ANALOG_SEL;
      `PPFM_IDX_PIN_STATUS:    return PPFM_R_PIN_STATUS;
      default:                 return PPFM_R_NONE;
    endcase
  endfunction

  // Pin inputs come from outside the clock domain
  ppfm_sync3 #(
    .W (13)
  ) u_sync (
    .mclk     (mclk),
    .resetn   (resetn),
    .async_in ({reset_pin_n, ac_zero_cross_in, port3_in, port2_in, port1_in}),
    .sync_out (pin_sync)
  );

  assign p1_s      = pin_sync[3:0];
  assign p2_s      = pin_sync[7:4];
  assign p3_s      = pin_sync[10:8];
  assign ac_s      = pin_sync[11];
  assign rst_pin_s = pin_sync[12];

  // Internal reset stretch
  ppfm_rst_stretch #(
    .COUNT (RST_STRETCH_CLKS)
  ) u_rst (
    .mclk      (mclk),
    .resetn    (resetn),
    .pin_ok    (rst_pin_s),
    .int_rst_q (int_rst)
  );

  assign int_rst_active = int_rst;

  // Bus slave: address phase capture; reads wait one cycle for flopped data
  assign addr_ok = hsel && htrans[1] && hready;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ahb_st_q <= PPFM_ST_IDLE;
      reg_q    <= PPFM_R_NONE;
    end
    else if (addr_ok)
    begin
      ahb_st_q <= hwrite ? PPFM_ST_WRITE : PPFM_ST_RDWAIT;
      reg_q    <= reg_decode(haddr[13:2]);
    end
    else
    begin
      case (ahb_st_q)
        PPFM_ST_RDWAIT: ahb_st_q <= PPFM_ST_RDOUT;
        default:        ahb_st_q <= PPFM_ST_IDLE;
      endcase
    end
  end

  assign hreadyout = (ahb_st_q != PPFM_ST_RDWAIT);
  assign hresp     = 1'b0; // Always OKAY; unmapped reads zero

  // Register writes; clearing on the pin too keeps the first internal reset cycle clean
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      port1_latch_q                <= `PPFM_RST4;
      port23_latch_q               <= `PPFM_RST7;
      port1_direction_q            <= `PPFM_RST4;
      port23_direction_reg_q       <= `PPFM_RST7;
      port23_pullup_reg_q          <= `PPFM_RST7;
      port1_drive_q                <= `PPFM_RST4;
      port23_drive_structure_reg_q <= `PPFM_RST7;
      key_irq_control_reg_q        <= 3'h0;
      zero_cross_control_reg_q     <= 2'h0;
      timer_mode_control_reg_q     <= 1'b0;
      timer_output_control_reg_q   <= 1'b0;
      buzzer_control_reg_q         <= `PPFM_RST8;
      analog_sel_q                 <= `PPFM_RST4;
    end
    else if (int_rst || !rst_pin_s)
    begin
      port1_latch_q                <= `PPFM_RST4;
      port23_latch_q               <= `PPFM_RST7;
      port1_direction_q            <= `PPFM_RST4;
      port23_direction_reg_q       <= `PPFM_RST7;
      port23_pullup_reg_q          <= `PPFM_RST7;
      port1_drive_q                <= `PPFM_RST4;
      port23_drive_structure_reg_q <= `PPFM_RST7;
      key_irq_control_reg_q        <= 3'h0;
      zero_cross_control_reg_q     <= 2'h0;
      timer_mode_control_reg_q     <= 1'b0;
      timer_output_control_reg_q   <= 1'b0;
      buzzer_control_reg_q         <= `PPFM_RST8;
      analog_sel_q                 <= `PPFM_RST4;
    end
    else if (ahb_st_q == PPFM_ST_WRITE)
    begin
      case (reg_q)
        PPFM_R_PORT01_DATA:   port1_latch_q <= hwdata[3:0];
        PPFM_R_PORT23_DATA:   port23_latch_q <= hwdata[6:0];
        PPFM_R_PORT1_DIR:     port1_direction_q <= hwdata[3:0];
        PPFM_R_PORT23_DIR:    port23_direction_reg_q <= hwdata[6:0];
        PPFM_R_PORT23_PULLUP: port23_pullup_reg_q <= hwdata[6:0];
        PPFM_R_PORT1_DRIVE:   port1_drive_q <= hwdata[3:0];
        PPFM_R_PORT23_DRIVE:  port23_drive_structure_reg_q <= hwdata[6:0];
        PPFM_R_KEY_IRQ:       key_irq_control_reg_q <= hwdata[2:0];
        PPFM_R_ZERO_CROSS:    zero_cross_control_reg_q <= hwdata[1:0];
        PPFM_R_TIMER_MODE:    timer_mode_control_reg_q <= hwdata[`PPFM_TM_SEL_BIT];
        PPFM_R_TIMER_OUT:     timer_output_control_reg_q <= hwdata[`PPFM_TCO_EN_BIT];
        PPFM_R_BUZZER:        buzzer_control_reg_q <= hwdata[7:0];
        PPFM_R_ANALOG_SEL:    analog_sel_q <= hwdata[3:0];
        default:              ;
      endcase
    end
  end

  // Read mux; pin status shows synchronised pins and internal reset
  always_comb
  begin
    case (reg_q)
      PPFM_R_PORT01_DATA:   rd_mux = {8'h00, port1_latch_q};
      PPFM_R_PORT23_DATA:   rd_mux = {5'h00, port23_latch_q};
      PPFM_R_PORT1_DIR:     rd_mux = {8'h00, port1_direction_q};
      PPFM_R_PORT23_DIR:    rd_mux = {5'h00, port23_direction_reg_q};
      PPFM_R_PORT23_PULLUP: rd_mux = {5'h00, port23_pullup_reg_q};
      PPFM_R_PORT1_DRIVE:   rd_mux = {8'h00, port1_drive_q};
      PPFM_R_PORT23_DRIVE:  rd_mux = {5'h00, port23_drive_structure_reg_q};
      PPFM_R_KEY_IRQ:       rd_mux = {9'h000, key_irq_control_reg_q};
      PPFM_R_ZERO_CROSS:    rd_mux = {10'h000, zero_cross_control_reg_q};
      PPFM_R_TIMER_MODE:    rd_mux = {11'h000, timer_mode_control_reg_q};
      PPFM_R_TIMER_OUT:     rd_mux = {11'h000, timer_output_control_reg_q};
      PPFM_R_BUZZER:        rd_mux = {4'h0, buzzer_control_reg_q};
      PPFM_R_ANALOG_SEL:    rd_mux = {8'h00, analog_sel_q};
      PPFM_R_PIN_STATUS:    rd_mux = {int_rst, p3_eff, p2_s & ~analog_sel_q, p1_s};
      default:              rd_mux = 12'h000;
    endcase
  end

  // Read data captured in the wait cycle
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      hrdata <= 32'h0000_0000;
    else if (ahb_st_q == PPFM_ST_RDWAIT)
      hrdata <= {20'h0_0000, rd_mux};
  end

  // System clock sync: half rate of mclk, phase locked to it
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      sysclk_sync_out_q <= 1'b0;
    else
      sysclk_sync_out_q <= ~sysclk_sync_out_q;
  end

  // Input paths; bit 1 may come from the zero-cross detector
  assign p3_eff[0] = p3_s[0];
  assign p3_eff[1] = zero_cross_control_reg_q[`PPFM_ZC_INPUT_SEL_BIT] ? ac_s : p3_s[1];
  assign p3_eff[2] = p3_s[2];
  assign zero_cross_irq_src = ac_s;
  assign interrupt_one      = p3_eff[1];
  assign key_irq_req        = key_irq_control_reg_q & p3_eff;

  // Timer source shared by the timer pin function and PWM
  assign timer_sel     = timer_mode_control_reg_q;
  assign timer_out_pin = timer_sel ? timer3_out : timer2_out;

  // Output values per pin: port1 [3:0], port2 [7:4], port3 [10:8]
  always_comb
  begin
    val_all[3:0] = port1_latch_q & ~buzzer_control_reg_q[7:4]
                 | {4{timer_out_pin}} & port1_latch_q & buzzer_control_reg_q[7:4];
    val_all[7:4] = port23_latch_q[3:0];
    if (int_rst || zero_cross_control_reg_q[`PPFM_ZC_SYNC_SEL_BIT])
      val_all[8] = sysclk_sync_out_q;
    else
      val_all[8] = port23_latch_q[`PPFM_P3_LSB];
    val_all[9] = port23_latch_q[`PPFM_P3_LSB+1];
    // Timer wins when both functions are selected
    if (timer_output_control_reg_q)
      val_all[10] = timer_out_pin;
    else if (buzzer_control_reg_q[`PPFM_BZ_EN_BIT])
      val_all[10] = buzzer_out;
    else
      val_all[10] = port23_latch_q[`PPFM_P3_LSB+2];
  end

  // Drive enables; analog pins never driven even if set to output
  assign drv_all[3:0]  = port1_direction_q;
  assign drv_all[7:4]  = port23_direction_reg_q[3:0] & ~analog_sel_q;
  assign drv_all[8]    = int_rst | port23_direction_reg_q[`PPFM_P3_LSB];
  assign drv_all[10:9] = port23_direction_reg_q[6:5];
  assign od_all        = {port23_drive_structure_reg_q, port1_drive_q};

  // Open-drain pins only sink; a high value releases the pin
  generate
    for (genvar i = 0; i < 11; i++)
    begin : g_pin
      assign oe_n_all[i] = ~(drv_all[i] & (~od_all[i] | ~val_all[i]));
    end
  endgenerate

  assign port1_out       = val_all[3:0];
  assign port1_oe_n      = oe_n_all[3:0];
  assign port2_out       = val_all[7:4];
  assign port2_oe_n      = oe_n_all[7:4];
  assign port2_pullup_en = port23_pullup_reg_q[3:0];
  assign analog_in_en    = analog_sel_q;
  assign port3_out       = val_all[10:8];
  assign port3_oe_n      = oe_n_all[10:8];
  assign port3_pullup_en = port23_pullup_reg_q[6:4];

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence s_dir_write;
    ahb_st_q == PPFM_ST_WRITE && reg_q == PPFM_R_PORT23_DIR && !int_rst;
  endsequence

  sequence s_pull_write;
    ahb_st_q == PPFM_ST_WRITE && reg_q == PPFM_R_PORT23_PULLUP && !int_rst;
  endsequence

  a_dir_write: assert property (s_dir_write |=> port23_direction_reg_q == $past(hwdata[6:0]))
    else $error("direction register did not take write");

  a_pullup_pin: assert property (s_pull_write |=> port3_pullup_en == $past(hwdata[6:4]))
    else $error("pull-up enable does not follow write");

  a_odrain_high: assert property (od_all[10] && val_all[10] |-> port3_oe_n[2])
    else $error("open-drain pin driven high");

  a_reset_hiz: assert property (int_rst |-> port3_oe_n[2:1] == 2'b11 && port3_pullup_en == 3'b000)
    else $error("port 3 not high impedance in reset");

  a_sync_drive: assert property (int_rst ##1 int_rst |-> !port3_oe_n[0]
                                 && port3_out[0] != $past(port3_out[0]))
    else $error("bit 0 not toggling sync in reset");

  a_p30_latch: assert property (!int_rst && !zero_cross_control_reg_q[0]
                                |-> port3_out[0] == port23_latch_q[4])
    else $error("bit 0 not showing latch");

  a_zc_path: assert property (zero_cross_control_reg_q[1] |-> interrupt_one == zero_cross_irq_src)
    else $error("bit 1 not taken from zero-cross");

  a_irq_plain: assert property (!zero_cross_control_reg_q[1] && $stable(p3_s[1])
                                |-> interrupt_one == p3_s[1])
    else $error("interrupt one not from pin");

  a_timer_prio: assert property (timer_output_control_reg_q && buzzer_control_reg_q[0]
                                 |-> port3_out[2] == timer_out_pin)
    else $error("buzzer overrode timer on bit 2");

  a_buzzer_sel: assert property (!timer_output_control_reg_q && buzzer_control_reg_q[0]
                                 |-> port3_out[2] == buzzer_out)
    else $error("bit 2 not showing buzzer");

  a_key_gate: assert property (key_irq_req == (key_irq_control_reg_q & {p3_s[2], interrupt_one, p3_s[0]}))
    else $error("key interrupt not enable AND input");

  a_pwm_and: assert property ((port1_out & buzzer_control_reg_q[7:4])
                              == (port1_latch_q & {4{timer_out_pin}} & buzzer_control_reg_q[7:4]))
    else $error("PWM pin not timer AND latch");

  a_analog_off: assert property (analog_sel_q[0] |-> port2_oe_n[0])
    else $error("analog pin driven");

endmodule
`default_nettype wire
